// >>> pcde_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcde_top #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  input wire pcde_pkg::pcde_periph_t periph,
  output logic [7:0] pc_level,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic [7:0] pd_oe,
  input wire logic [2:0] pe_in,
  output logic [2:0] pe_out,
  output logic [2:0] pe_oe,
  output logic [2:0] pe_analog
);
  // ****************************************
  // declarations
  // ****************************************
  pcde_pkg::pcde_wstate_t wstate_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [AW-1:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic ar_fire;
  logic wr_hit;
  logic wr_en;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [7:0] lat_c_reg;
  logic [7:0] lat_d_reg;
  logic [2:0] lat_e_reg;
  logic [7:0] dir_c_reg;
  logic [7:0] dir_d_reg;
  logic [2:0] dir_e_reg;
  logic mode_reg;
  logic [7:0] analog_reg;
  logic [7:0] pc_sync;
  logic [7:0] pd_sync;
  logic [2:0] pe_sync;
  logic [7:0] pc_sel;
  logic [7:0] pc_out_reg;
  logic [7:0] pc_oe_reg;
  logic [7:0] psp_in;
  pcde_pkg::pcde_psp_stat_t stat;

  // ****************************************
  // address decode helper
  // ****************************************
  // true when a byte address equals a register index times four
  function automatic logic is_reg(input logic [AW-1:0] a, input logic [7:0] idx);
    logic [AW-1:0] want;
    want = AW'(idx) << pcde_pkg::ADDR_LSB;
    is_reg = (a == want);
  endfunction

  // true when a byte address hits any register
  function automatic logic any_reg(input logic [AW-1:0] a);
    any_reg = is_reg(a, pcde_pkg::IDX_PORT_C) | is_reg(a, pcde_pkg::IDX_PORT_D)
      | is_reg(a, pcde_pkg::IDX_PORT_E) | is_reg(a, pcde_pkg::IDX_DIR_C)
      | is_reg(a, pcde_pkg::IDX_DIR_D) | is_reg(a, pcde_pkg::IDX_DIR_E)
      | is_reg(a, pcde_pkg::IDX_ANALOG);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  pcde_sync #(.W(8)) u_sync_c (
    .clk(clk),
    .resetn(resetn),
    .d(pc_in),
    .q(pc_sync)
  );

  pcde_sync #(.W(8)) u_sync_d (
    .clk(clk),
    .resetn(resetn),
    .d(pd_in),
    .q(pd_sync)
  );

  pcde_sync #(.W(3)) u_sync_e (
    .clk(clk),
    .resetn(resetn),
    .d(pe_in),
    .q(pe_sync)
  );

  // ****************************************
  // write channel
  // ****************************************
  assign awready = ~aw_held_reg & (wstate_reg == pcde_pkg::WS_IDLE);
  assign wready = ~w_held_reg & (wstate_reg == pcde_pkg::WS_IDLE);
  assign wr_fire = aw_held_reg & w_held_reg & (wstate_reg == pcde_pkg::WS_IDLE);
  assign wr_hit = any_reg(waddr_reg);
  assign wr_en = wr_fire & wr_hit & wlane_reg;

  // address and data taken in either order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
    end
  end

  // response state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wstate_reg <= pcde_pkg::WS_IDLE;
      bresp_reg <= pcde_pkg::RESP_OKAY;
    end else begin
      case (wstate_reg)
        pcde_pkg::WS_IDLE: begin
          if (wr_fire) begin
            wstate_reg <= pcde_pkg::WS_RESP;
            bresp_reg <= wr_hit ? pcde_pkg::RESP_OKAY : pcde_pkg::RESP_DECERR;
          end
        end
        pcde_pkg::WS_RESP: begin
          if (bready) begin
            wstate_reg <= pcde_pkg::WS_IDLE;
          end
        end
        default: begin
          wstate_reg <= pcde_pkg::WS_IDLE;
        end
      endcase
    end
  end

  assign bvalid = (wstate_reg == pcde_pkg::WS_RESP);
  assign bresp = bresp_reg;

  // ****************************************
  // read channel
  // ****************************************
  assign arready = ~rvalid_reg;
  assign ar_fire = arvalid & arready;

  // read data select
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    if (is_reg(araddr, pcde_pkg::IDX_PORT_C)) begin
      rd_byte = pc_sync;
    end else if (is_reg(araddr, pcde_pkg::IDX_PORT_D)) begin
      rd_byte = mode_reg ? psp_in : pd_sync;
    end else if (is_reg(araddr, pcde_pkg::IDX_PORT_E)) begin
      rd_byte = {5'h00, pe_sync & ~pe_analog};
    end else if (is_reg(araddr, pcde_pkg::IDX_DIR_C)) begin
      rd_byte = dir_c_reg;
    end else if (is_reg(araddr, pcde_pkg::IDX_DIR_D)) begin
      rd_byte = dir_d_reg;
    end else if (is_reg(araddr, pcde_pkg::IDX_DIR_E)) begin
      rd_byte = {stat.input_full_flag, stat.output_full_flag, stat.input_overrun_flag, mode_reg, 1'b0, dir_e_reg};
    end else if (is_reg(araddr, pcde_pkg::IDX_ANALOG)) begin
      rd_byte = analog_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= pcde_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_hit ? pcde_pkg::RESP_OKAY : pcde_pkg::RESP_DECERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ****************************************
  // output latches
  // ****************************************
  // data writes land in latches, never in the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lat_c_reg <= 8'h00;
      lat_d_reg <= 8'h00;
      lat_e_reg <= 3'h0;
    end else if (wr_en) begin
      if (is_reg(waddr_reg, pcde_pkg::IDX_PORT_C)) begin
        lat_c_reg <= wbyte_reg;
      end else if (is_reg(waddr_reg, pcde_pkg::IDX_PORT_D)) begin
        lat_d_reg <= wbyte_reg;
      end else if (is_reg(waddr_reg, pcde_pkg::IDX_PORT_E)) begin
        lat_e_reg <= wbyte_reg[2:0];
      end
    end
  end

  // ****************************************
  // direction and configuration registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dir_c_reg <= pcde_pkg::DIR_C_RST;
      dir_d_reg <= pcde_pkg::DIR_D_RST;
      dir_e_reg <= pcde_pkg::DIR_E_RST;
      mode_reg <= 1'b0;
    end else if (wr_en) begin
      if (is_reg(waddr_reg, pcde_pkg::IDX_DIR_C)) begin
        dir_c_reg <= wbyte_reg;
      end else if (is_reg(waddr_reg, pcde_pkg::IDX_DIR_D)) begin
        dir_d_reg <= wbyte_reg;
      end else if (is_reg(waddr_reg, pcde_pkg::IDX_DIR_E)) begin
        dir_e_reg <= wbyte_reg[pcde_pkg::E_DIR_W-1:0];
        mode_reg <= wbyte_reg[pcde_pkg::E_MODE_BIT];
      end
    end
  end

  // analog config, zero after reset leaves port e analog
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_reg <= pcde_pkg::ANALOG_RST;
    end else if (wr_en && is_reg(waddr_reg, pcde_pkg::IDX_ANALOG)) begin
      analog_reg <= wbyte_reg & pcde_pkg::ANALOG_WMASK;
    end
  end

  // port e pins analog unless the config field selects digital
  assign pe_analog = (analog_reg[pcde_pkg::PCFG_LSB +: 3] == pcde_pkg::PCFG_E_DIGITAL) ? 3'h0 : 3'h7;

  // ****************************************
  // slave port
  // ****************************************
  // strobes are read straight from port e pins; digital setup is firmware's job
  pcde_psp u_psp (
    .clk(clk),
    .resetn(resetn),
    .mode(mode_reg),
    .cs_n(pe_sync[2]),
    .rd_n(pe_sync[0]),
    .wr_n(pe_sync[1]),
    .din(pd_sync),
    .fw_wr_data(wr_en & is_reg(waddr_reg, pcde_pkg::IDX_PORT_D)),
    .fw_rd_data(ar_fire & is_reg(araddr, pcde_pkg::IDX_PORT_D)),
    .ovr_wr(wr_en & is_reg(waddr_reg, pcde_pkg::IDX_DIR_E)),
    .ovr_wdata(wbyte_reg[pcde_pkg::E_OVR_BIT]),
    .in_latch(psp_in),
    .stat(stat)
  );

  // ****************************************
  // port c pin drive
  // ****************************************
  // peripherals own only their documented pins
  assign pc_sel = pcde_pkg::PC_SHARE_MASK & periph.ovr;

  // registered drive, peripheral direction wins while enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_oe_reg <= 8'h00;
      pc_out_reg <= 8'h00;
    end else begin
      pc_oe_reg <= (pc_sel & ~periph.dir_in) | (~pc_sel & ~dir_c_reg);
      pc_out_reg <= (pc_sel & periph.dout) | (~pc_sel & lat_c_reg);
    end
  end

  assign pc_oe = pc_oe_reg;
  assign pc_out = pc_out_reg;
  assign pc_level = pc_sync; // synced pins for capture, serial and timer inputs

  // ****************************************
  // port d and e pin drive
  // ****************************************
  // slave mode: host read strobe drives the bus, direction ignored
  assign pd_oe = mode_reg ? {8{stat.drive}} : ~dir_d_reg;
  assign pd_out = lat_d_reg;
  assign pe_oe = ~dir_e_reg;
  assign pe_out = lat_e_reg;
endmodule
`default_nettype wire

// >>> pcde_pkg.sv
// ****************************************
// shared constants and types
// ****************************************
package pcde_pkg;

  // ****************************************
  // register indices, byte address is index times four
  // ****************************************
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] IDX_PORT_C = 8'h07;
  localparam logic [7:0] IDX_PORT_D = 8'h08;
  localparam logic [7:0] IDX_PORT_E = 8'h09;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_DIR_D = 8'h88;
  localparam logic [7:0] IDX_DIR_E = 8'h89;
  localparam logic [7:0] IDX_ANALOG = 8'h9F;

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [7:0] DIR_C_RST = 8'hFF;
  localparam logic [7:0] DIR_D_RST = 8'hFF;
  localparam logic [2:0] DIR_E_RST = 3'h7;
  localparam logic [7:0] ANALOG_RST = 8'h00;
  localparam logic [7:0] ANALOG_WMASK = 8'h8F; // result format bit and pin config field
  localparam int E_DIR_W = 3;
  localparam int PCFG_LSB = 1; // upper three bits of the pin config field
  localparam logic [2:0] PCFG_E_DIGITAL = 3'h3; // field 6 or 7: port e pins digital
  localparam int E_OVR_BIT = 5;
  localparam int E_MODE_BIT = 4;
  localparam logic [7:0] PC_SHARE_MASK = 8'hC7; // bits 0,1,2,6,7 carry peripherals

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] ovr; // peripheral enabled and owning the pin
    logic [7:0] dir_in; // 1 forces input, 0 forces output
    logic [7:0] dout; // peripheral output value
  } pcde_periph_t;

  typedef struct packed {
    logic input_full_flag;
    logic output_full_flag;
    logic input_overrun_flag;
    logic drive;
  } pcde_psp_stat_t;

  typedef enum logic [0:0] {
    WS_IDLE = 1'b0,
    WS_RESP = 1'b1
  } pcde_wstate_t;

endpackage

// >>> pcde_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// three-stage pin synchroniser, accept when stages two and three agree
// ****************************************
module pcde_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] q_reg;

  // shift chain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
    end else begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // take a bit only once two stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= (~(ff2_reg ^ ff3_reg) & ff3_reg) | ((ff2_reg ^ ff3_reg) & q_reg);
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// >>> pcde_psp.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// parallel slave port strobe handling and flags
// ****************************************
module pcde_psp (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] din,
  input wire logic fw_wr_data,
  input wire logic fw_rd_data,
  input wire logic ovr_wr,
  input wire logic ovr_wdata,
  output logic [7:0] in_latch,
  output pcde_pkg::pcde_psp_stat_t stat
);
  logic wr_act;
  logic rd_act;
  logic wr_act_reg;
  logic rd_act_reg;
  logic wr_done;
  logic rd_start;
  logic [7:0] in_latch_reg;
  logic ibf_reg;
  logic obf_reg;
  logic input_overrun_flag_reg;

  // strobes count only while selected and in slave mode
  assign wr_act = mode & ~cs_n & ~wr_n;
  assign rd_act = mode & ~cs_n & ~rd_n;
  assign wr_done = wr_act_reg & ~wr_act;
  assign rd_start = rd_act & ~rd_act_reg;

  // edge history of the strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_act_reg <= 1'b0;
      rd_act_reg <= 1'b0;
    end else begin
      wr_act_reg <= wr_act;
      rd_act_reg <= rd_act;
    end
  end

  // host data captured while the write is active
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_latch_reg <= 8'h00;
    end else if (wr_act) begin
      in_latch_reg <= din;
    end
  end

  // input full: set at end of host write, set beats firmware read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ibf_reg <= 1'b0;
    end else if (!mode) begin
      ibf_reg <= 1'b0;
    end else if (wr_done) begin
      ibf_reg <= 1'b1;
    end else if (fw_rd_data) begin
      ibf_reg <= 1'b0;
    end
  end

  // output full: set by firmware write, cleared when host read begins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      obf_reg <= 1'b0;
    end else if (!mode) begin
      obf_reg <= 1'b0;
    end else if (fw_wr_data) begin
      obf_reg <= 1'b1;
    end else if (rd_start) begin
      obf_reg <= 1'b0;
    end
  end

  // overrun: hardware set wins, survives leaving slave mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_overrun_flag_reg <= 1'b0;
    end else if (wr_done && ibf_reg) begin
      input_overrun_flag_reg <= 1'b1;
    end else if (ovr_wr) begin
      input_overrun_flag_reg <= ovr_wdata;
    end
  end

  assign in_latch = in_latch_reg;
  assign stat.input_full_flag = ibf_reg;
  assign stat.output_full_flag = obf_reg;
  assign stat.input_overrun_flag = input_overrun_flag_reg;
  assign stat.drive = rd_act;
endmodule
`default_nettype wire

// >>> pcde_props.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// bus and port relations
// ********
module pcde_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pc_oe,
  input wire pcde_pkg::pcde_periph_t periph,
  input wire logic [2:0] pe_analog
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_aw_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped early");
  a_wr_resp: assert property (awvalid && awready && wvalid && wready |-> !bvalid ##2 bvalid)
    else $error("write answer late");
  a_ar_ready: assert property (arready == !rvalid)
    else $error("read ready wrong");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer unstable");
  a_rd_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_dec_zero: assert property (rvalid && rresp == 2'h3 |-> rdata == 32'h0)
    else $error("unmapped read data not zero");
  a_periph_dir: assert property ((periph.ovr & pcde_pkg::PC_SHARE_MASK) != 8'h00 |=>
    ((pc_oe ^ ~$past(periph.dir_in)) & $past(periph.ovr) & pcde_pkg::PC_SHARE_MASK) == 8'h00)
    else $error("peripheral direction not applied");
  a_analog_all: assert property ((pe_analog == 3'h7 || pe_analog == 3'h0)
    && ($past(resetn) || pe_analog == 3'h7))
    else $error("analog select split");
endmodule
bind pcde_top pcde_props u_props (.clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .pc_oe(pc_oe), .periph(periph), .pe_analog(pe_analog));
`default_nettype wire

// >>> pcde_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// host bus and port pins model
// ********
module pcde_host (
  input wire logic clk,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  input wire logic [2:0] pe_out,
  input wire logic [2:0] pe_oe,
  output logic [7:0] pd_in,
  output logic [2:0] pe_in
);
  logic [2:0] strobe_n = 3'h7; // chip select, write, read
  logic [7:0] host_d = 8'h00;
  logic host_en = 1'b0;
  logic [7:0] idle_pat = 8'hA5;
  // released lines keep no value
  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
  end
  // wire levels from every driver
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & (host_en ? host_d : idle_pat));
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & strobe_n);
  // one host cycle, strobes low eight cycles, high eight after
  task automatic cyc(input logic cs_n, input logic wr_op, input logic [7:0] dat, output logic [7:0] got);
    @(posedge clk);
    host_d <= dat;
    host_en <= wr_op;
    strobe_n <= {cs_n, ~wr_op, wr_op};
    repeat (8) @(posedge clk);
    got = pd_in;
    strobe_n <= 3'h7;
    repeat (8) @(posedge clk);
    host_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// self-checking bench
// ********
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, lanes = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [7:0] pc_in, pc_out, pc_oe, pc_level, pd_in, pd_out, pd_oe, pc_ext = 8'h00;
  logic [7:0] q, d, e, x, v;
  logic [2:0] pe_in, pe_out, pe_oe, pe_analog;
  pcde_pkg::pcde_periph_t periph = '0;
  int err_count = 0, check_count = 0, cycles = 0, seed = 32'h5413;
  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      report_and_stop;
    end
  end
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
  pcde_top DUT (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .periph(periph), .pc_level(pc_level), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe), .pe_analog(pe_analog));
  pcde_host host (.clk(clk), .pd_out(pd_out), .pd_oe(pd_oe), .pe_out(pe_out), .pe_oe(pe_oe),
    .pd_in(pd_in), .pe_in(pe_in));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bus write, both channels offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    bit a, w;
    a = 0;
    w = 0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, dat};
    wstrb <= lanes;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      a = a | (awvalid & awready);
      w = w | (wvalid & wready);
      awvalid <= !a;
      wvalid <= !w;
    end while (!(a && w));
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // bus read
  task automatic rd(input logic [7:0] idx);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    q = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(q, exp);
  endtask
  // expected port c drive and pin level
  function automatic logic [7:0] c_oe(input logic [7:0] dir, input pcde_pkg::pcde_periph_t p);
    logic [7:0] m;
    m = p.ovr & pcde_pkg::PC_SHARE_MASK;
    return (m & ~p.dir_in) | (~m & ~dir);
  endfunction
  function automatic logic [7:0] c_pin(input logic [7:0] lat, input logic [7:0] dir,
    input pcde_pkg::pcde_periph_t p, input logic [7:0] ext);
    logic [7:0] m, o;
    m = p.ovr & pcde_pkg::PC_SHARE_MASK;
    o = c_oe(dir, p);
    return (o & ((m & p.dout) | (~m & lat))) | (~o & ext);
  endfunction
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rdc(pcde_pkg::IDX_DIR_C, 8'hFF);
    rdc(pcde_pkg::IDX_DIR_D, 8'hFF);
    rdc(pcde_pkg::IDX_DIR_E, 8'h07);
    rdc(pcde_pkg::IDX_ANALOG, 8'h00);
    chk({5'h0, pe_analog}, 8'h07);
    rdc(pcde_pkg::IDX_PORT_E, 8'h00);
    rd(8'h10);
    chk(8'(r), 8'(pcde_pkg::RESP_DECERR));
    wr(8'h10, 8'h55);
    chk(8'(r), 8'(pcde_pkg::RESP_DECERR));
    // write with no byte lanes: answered, register untouched
    lanes = 4'h0;
    wr(pcde_pkg::IDX_DIR_C, 8'h00);
    lanes = 4'hF;
    chk(8'(r), 8'(pcde_pkg::RESP_OKAY));
    rdc(pcde_pkg::IDX_DIR_C, 8'hFF);
    // port c and d as i/o, random port c peripherals after the first four passes
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      x = 8'($random(seed));
      wr(pcde_pkg::IDX_PORT_C, d);
      wr(pcde_pkg::IDX_DIR_C, e);
      wr(pcde_pkg::IDX_PORT_D, d);
      wr(pcde_pkg::IDX_DIR_D, e);
      pc_ext <= x;
      periph <= (i < 4) ? '0 : pcde_pkg::pcde_periph_t'(24'($random(seed)));
      host.host_d <= x;
      host.host_en <= 1'b1;
      repeat (6) @(posedge clk);
      chk(pc_oe, c_oe(e, periph));
      chk(pc_level, c_pin(d, e, periph, x));
      chk(pd_oe, ~e);
      rdc(pcde_pkg::IDX_PORT_C, c_pin(d, e, periph, x));
      rdc(pcde_pkg::IDX_PORT_D, (~e & d) | (e & x));
    end
    host.host_en <= 1'b0;
    // port e control and analog pins
    wr(pcde_pkg::IDX_DIR_E, 8'hEF);
    rdc(pcde_pkg::IDX_DIR_E, 8'h27);
    wr(pcde_pkg::IDX_DIR_E, 8'h02);
    rdc(pcde_pkg::IDX_DIR_E, 8'h02);
    chk({5'h0, pe_oe}, 8'h05);
    wr(pcde_pkg::IDX_PORT_E, 8'h04);
    rdc(pcde_pkg::IDX_PORT_E, 8'h00);
    wr(pcde_pkg::IDX_ANALOG, 8'hF7);
    rdc(pcde_pkg::IDX_ANALOG, 8'h87);
    chk({5'h0, pe_analog}, 8'h00);
    repeat (6) @(posedge clk);
    rdc(pcde_pkg::IDX_PORT_E, 8'h06);
    // slave port traffic
    wr(pcde_pkg::IDX_DIR_E, 8'h17);
    wr(pcde_pkg::IDX_DIR_D, 8'h00);
    repeat (6) @(posedge clk);
    chk(pd_oe, 8'h00);
    d = 8'($random(seed));
    e = 8'($random(seed));
    host.cyc(1'b0, 1'b1, d, v);
    rdc(pcde_pkg::IDX_DIR_E, 8'h97);
    host.cyc(1'b0, 1'b1, e, v);
    rdc(pcde_pkg::IDX_DIR_E, 8'hB7);
    rdc(pcde_pkg::IDX_PORT_D, e);
    wr(pcde_pkg::IDX_DIR_E, 8'h17);
    rdc(pcde_pkg::IDX_DIR_E, 8'h17);
    wr(pcde_pkg::IDX_PORT_D, d);
    rdc(pcde_pkg::IDX_DIR_E, 8'h57);
    host.cyc(1'b0, 1'b0, 8'h00, v);
    chk(v, d);
    rdc(pcde_pkg::IDX_DIR_E, 8'h17);
    host.cyc(1'b1, 1'b1, e, v);
    rdc(pcde_pkg::IDX_DIR_E, 8'h17);
    host.cyc(1'b0, 1'b1, e, v);
    host.cyc(1'b0, 1'b1, d, v);
    wr(pcde_pkg::IDX_PORT_D, e);
    rdc(pcde_pkg::IDX_DIR_E, 8'hF7);
    wr(pcde_pkg::IDX_DIR_E, 8'h27);
    rdc(pcde_pkg::IDX_DIR_E, 8'h27);
    report_and_stop;
  end
endmodule
`default_nettype wire
